/* File: inc/irq_status_threshold_consts.svh */
// Constants for the interrupt status and threshold register block.
// Assumes a 32-bit APB register bus with one aligned word per register.
`ifndef IRQ_STATUS_THRESHOLD_CONSTS_SVH
`define IRQ_STATUS_THRESHOLD_CONSTS_SVH

// Register byte offsets
`define ENABLE_STATE_UPPER_OFS 8'h04
`define WAITING_STATE_LOWER_OFS 8'h20
`define WAITING_STATE_UPPER_OFS 8'h24
`define PRIORITY_CUTOFF_OFS 8'h40

// Reset values
`define ENABLE_STATE_UPPER_RST 32'h0000_0000
`define WAITING_STATE_LOWER_RST 32'h0000_0000
`define WAITING_STATE_UPPER_RST 32'h0000_0000
`define PRIORITY_CUTOFF_RST 8'h00

// Number of interrupt lines and lines that exist
`define IRQ_COUNT 39
`define IRQ_ID_W 6
`define IRQ_VALID_MASK 39'h7f_ffff_500c

// Field layout
`define UPPER_FIELD_W 7
`define UPPER_BASE 32
`define CUTOFF_FIELD_W 8
`define CUTOFF_WMASK 8'hc0
`define PRIO_W 8
`define APB_ADDR_W 8
`define APB_DATA_W 32
`define SYNC_STAGES 2

`endif

/* File: inc/irq_status_threshold_pkg.sv */
// Types for the interrupt status and threshold register block.
// Assumes the constants header sits on the include path.
`include "irq_status_threshold_consts.svh"

package irq_status_threshold_pkg;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

  // Request handed to the core for service
  typedef struct packed {
    logic valid;
    logic [`IRQ_ID_W-1:0] id;
  } dispatch_t;

  // Acknowledge from the core when it takes an interrupt
  typedef struct packed {
    logic valid;
    logic [`IRQ_ID_W-1:0] id;
  } service_ack_t;

endpackage : irq_status_threshold_pkg

/* File: src/irq_sync2.sv */
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/1ns
`include "irq_status_threshold_consts.svh"

module irq_sync2 #(
  parameter int WIDTH = `IRQ_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by second stage
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q; // Second stage, safe to use
  logic [WIDTH-1:0] stable_d;

  ////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    meta_d = async_in;
    stable_d = meta_q;
  end

  // Both stages clear under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_out = stable_q;

endmodule : irq_sync2

/* File: src/irq_status_threshold_regs.sv */
// Interrupt status and priority threshold block with an APB slave.
// Assumes enable state and priorities arrive from same-clock logic,
// interrupt sources arrive as asynchronous levels.
`timescale 1ns/1ns
`include "irq_status_threshold_consts.svh"

// Operation
// - Enable bits for interrupts 32-38 read back
// - Waiting bits 16-31 in lower register top half
// - Waiting bits 14, 12, 3, 2; rest reserved
// - Waiting bits 32-38 in upper register low bits
// - Priority below cutoff is never dispatched
// - Cutoff of zero disables priority masking; enable flags still gate
// - Only cutoff bits 7:6 stored; 5:0 zero
module irq_status_threshold_regs
  import irq_status_threshold_pkg::*;
#(
  parameter int NUM_IRQ = `IRQ_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt side
  input wire logic [NUM_IRQ-1:0] irq_source,
  input wire logic [NUM_IRQ-1:0] irq_enabled_flag,
  input wire logic [NUM_IRQ-1:0][`PRIO_W-1:0] irq_priority,
  input wire service_ack_t service_ack,
  output dispatch_t dispatch,
  output logic [`CUTOFF_FIELD_W-1:0] priority_cutoff
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [NUM_IRQ-1:0] VALID_MASK = NUM_IRQ'(`IRQ_VALID_MASK);

  logic [NUM_IRQ-1:0] src_sync; // Sources after two flops
  logic [NUM_IRQ-1:0] src_prev_q; // Last synchronised level
  logic [NUM_IRQ-1:0] src_prev_d;
  logic [NUM_IRQ-1:0] src_rise; // New request edges

  logic [NUM_IRQ-1:0] waiting_q; // Sticky waiting flags
  logic [NUM_IRQ-1:0] waiting_d;

  logic [`CUTOFF_FIELD_W-1:0] cutoff_q; // Only top two bits ever set
  logic [`CUTOFF_FIELD_W-1:0] cutoff_d;

  bus_state_t state_q; // Bus handshake state
  bus_state_t state_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [`APB_DATA_W-1:0] prdata_q;
  logic [`APB_DATA_W-1:0] prdata_d;

  logic [NUM_IRQ-1:0] eligible; // Waiting, enabled and at or above cutoff
  dispatch_t dispatch_q; // Registered request to the core
  dispatch_t dispatch_d;

  logic [`APB_DATA_W-1:0] read_word; // Decoded read data
  logic addr_hit; // Address maps to a register
  logic wr_commit; // Write takes effect this edge

  ////////////////////////////////////////////////////////////////
  // Source synchronisation

  // Sources are outside the clock domain, so two flops first
  irq_sync2 #(
    .WIDTH(NUM_IRQ)
  ) u_src_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(irq_source),
    .sync_out(src_sync)
  );

  // Edge detect on the stable stage only
  always_comb begin
    src_prev_d = src_sync;
    src_rise = src_sync & ~src_prev_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Waiting flags

  // Set on a source edge, cleared when the core takes it; set wins
  always_comb begin
    waiting_d = waiting_q;
    if (service_ack.valid && (int'(service_ack.id) < NUM_IRQ)) begin
      waiting_d[service_ack.id] = 1'b0; // Core accepted this one
    end
    waiting_d = (waiting_d | src_rise) & VALID_MASK;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waiting_q <= '0;
    end else begin
      waiting_q <= waiting_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Priority cutoff and dispatch

  // Eligibility per line against the cutoff
  always_comb begin
    eligible = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (waiting_q[i] && irq_enabled_flag[i] && VALID_MASK[i]) begin
        if (cutoff_q == '0) begin
          eligible[i] = 1'b1;
        end else if (irq_priority[i] >= cutoff_q) begin
          eligible[i] = 1'b1;
        end
      end
    end
  end

  // Lowest number wins; line priorities only gate against the cutoff, never rank
  always_comb begin
    dispatch_d.valid = 1'b0;
    dispatch_d.id = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        dispatch_d.valid = 1'b1;
        dispatch_d.id = `IRQ_ID_W'(i);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispatch_q <= '0;
    end else begin
      dispatch_q <= dispatch_d;
    end
  end

  // Cutoff register; low six bits cannot hold a one
  always_comb begin
    cutoff_d = cutoff_q;
    if (wr_commit && (paddr == `PRIORITY_CUTOFF_OFS) && pstrb[0]) begin
      cutoff_d = pwdata[`CUTOFF_FIELD_W-1:0] & `CUTOFF_WMASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cutoff_q <= `PRIORITY_CUTOFF_RST;
    end else begin
      cutoff_q <= cutoff_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read decode

  // Reserved bits read zero in every word
  always_comb begin
    read_word = '0;
    addr_hit = 1'b1;
    if (paddr == `ENABLE_STATE_UPPER_OFS) begin
      read_word[`UPPER_FIELD_W-1:0] =
        irq_enabled_flag[`UPPER_BASE +: `UPPER_FIELD_W];
    end else if (paddr == `WAITING_STATE_LOWER_OFS) begin
      read_word = waiting_q[31:0];
    end else if (paddr == `WAITING_STATE_UPPER_OFS) begin
      read_word[`UPPER_FIELD_W-1:0] =
        waiting_q[`UPPER_BASE +: `UPPER_FIELD_W];
    end else if (paddr == `PRIORITY_CUTOFF_OFS) begin
      read_word[`CUTOFF_FIELD_W-1:0] = cutoff_q;
    end else begin
      addr_hit = 1'b0; // Unmapped: error answer
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB handshake

  // Write lands only at the edge where pready is seen high
  assign wr_commit = psel && penable && pready_q && pwrite && addr_hit;

  // One wait state, then a registered answer
  always_comb begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    case (state_q)
      BUS_IDLE: begin
        if (psel && penable) begin
          state_d = BUS_RESP;
          pready_d = 1'b1;
          pslverr_d = ~addr_hit;
          prdata_d = pwrite ? '0 : read_word;
        end
      end
      BUS_RESP: begin
        state_d = BUS_IDLE; // Answer given, wait for next access
        prdata_d = '0;
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dispatch = dispatch_q;
  assign priority_cutoff = cutoff_q;

endmodule : irq_status_threshold_regs

/* File: verification/irq_status_threshold_props.sv */
// Port checker for the status and threshold block.
// Assumes it is bound to each instance of the block.
`timescale 1ns/1ns
`include "irq_status_threshold_consts.svh"
module irq_status_threshold_props
  import irq_status_threshold_pkg::*;
#(
  parameter int NUM_IRQ = `IRQ_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [`APB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_IRQ-1:0] irq_enabled_flag,
  input wire logic [NUM_IRQ-1:0][`PRIO_W-1:0] irq_priority,
  input wire dispatch_t dispatch,
  input wire logic [`CUTOFF_FIELD_W-1:0] priority_cutoff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read answer at one offset
  sequence rd_at(a);
    pready && !pwrite && paddr == a;
  endsequence
  // Threshold write completing with lane 0 set
  sequence cut_wr;
    psel && penable && pwrite && paddr == 8'h40 && pstrb[0] && pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("no answer after one wait");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  chk_enable_read: assert property (rd_at(8'h04) |-> prdata == {25'h0, $past(irq_enabled_flag[38:32])})
    else $error("enable state read wrong");
  chk_lower_reserved: assert property (rd_at(8'h20) |-> (prdata & 32'h0000_aff3) == 32'h0)
    else $error("lower reserved bits set");
  chk_upper_reserved: assert property (rd_at(8'h24) |-> prdata[31:7] == 25'h0)
    else $error("upper reserved bits set");
  chk_cutoff_low: assert property (priority_cutoff[5:0] == 6'h0) else $error("cutoff low bits set");
  chk_cutoff_write: assert property (cut_wr |=> priority_cutoff == ($past(pwdata[7:0]) & 8'hc0))
    else $error("cutoff write wrong");
  chk_cutoff_block: assert property (dispatch.valid && $past(priority_cutoff) != 8'h0
    |-> irq_priority[dispatch.id] >= $past(priority_cutoff)) else $error("low priority dispatched");
  chk_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle bus not zero");
  chk_dispatch_line: assert property (dispatch.valid |-> dispatch.id inside {2, 3, 12, 14, [16:38]})
    else $error("missing line dispatched");
endmodule : irq_status_threshold_props

bind irq_status_threshold_regs irq_status_threshold_props #(.NUM_IRQ(NUM_IRQ)) u_props (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .irq_enabled_flag, .irq_priority, .dispatch, .priority_cutoff);

/* File: verification/core_model.sv */
// Core model: takes each dispatched interrupt after a set wait.
// Assumes ack_delay of 2 or more, so one grant is acknowledged once.
`timescale 1ns/1ns
module core_model
  import irq_status_threshold_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ack_on,
  input wire logic [3:0] ack_delay,
  input wire dispatch_t dispatch,
  output service_ack_t service_ack
);
  logic [3:0] wait_q; // Cycles the current grant has waited
  // Count while a grant stands, then pulse one acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      service_ack <= '0;
    end else begin
      service_ack <= '0;
      if (!(ack_on && dispatch.valid)) begin
        wait_q <= 4'h0;
      end else if (wait_q == ack_delay) begin
        wait_q <= 4'h0;
        service_ack <= {1'b1, dispatch.id};
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : core_model

/* File: verification/irq_status_threshold_regs_bench.sv */
// Bench for the status and threshold block: APB tasks and scenarios.
// Assumes the package, the checker and the core model compile first.
`timescale 1ns/1ns
module irq_status_threshold_regs_bench
  import irq_status_threshold_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_on = 1'b0, e;
  logic [7:0] paddr = 8'h00, priority_cutoff;
  logic [31:0] pwdata = 32'h0, r, prdata;
  logic [3:0] pstrb = 4'h0, ack_delay = 4'h2;
  logic [38:0] irq_source = '0, irq_enabled_flag = '0;
  logic [38:0][7:0] irq_priority;
  logic pready, pslverr;
  service_ack_t service_ack;
  dispatch_t dispatch;
  int mismatches = 0, total_checks = 0;
  always #5 core_clk = ~core_clk;
  irq_status_threshold_regs u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .irq_source, .irq_enabled_flag, .irq_priority, .service_ack, .dispatch,
    .priority_cutoff);
  core_model u_core (.core_clk, .rst_n, .ack_on, .ack_delay, .dispatch, .service_ack);
  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; answer taken at the rising edge that sees pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(r, exp);
  endtask : rd
  // Grant read at the second edge after a change, as the first edge only registers it
  task grant(input logic [5:0] id);
    repeat (2) @(posedge core_clk);
    chk({25'h0, dispatch}, {25'h0, 1'b1, id});
  endtask : grant
  task finish_test;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 39; i++) irq_priority[i] = (i < 30) ? 8'h40 : 8'hc0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h08, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    apb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
    rd(8'h40, 32'hc0);
    chk({24'h0, priority_cutoff}, 32'hc0);
    apb(1'b1, 8'h40, 32'h0, 4'he);
    rd(8'h40, 32'hc0);
    $display("test cutoff done");
    irq_enabled_flag <= 39'h55_0000_0000;
    apb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    rd(8'h04, 32'h55);
    irq_source <= 39'h7f_ffff_ffff;
    repeat (5) @(posedge core_clk);
    rd(8'h20, 32'hffff_500c);
    rd(8'h24, 32'h7f);
    $display("test status done");
    grant(6'd32);
    irq_enabled_flag <= 39'h7f_ffff_ffff;
    grant(6'd30);
    apb(1'b1, 8'h40, 32'h0, 4'h1);
    grant(6'd2);
    apb(1'b1, 8'h40, 32'h80, 4'h1);
    grant(6'd30);
    apb(1'b1, 8'h40, 32'h0, 4'h1);
    ack_on <= 1'b1;
    repeat (300) @(posedge core_clk);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    chk({31'h0, dispatch.valid}, 32'h0);
    $display("test dispatch done");
    finish_test();
  end
  // Watchdog against a hung transfer
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
endmodule : irq_status_threshold_regs_bench
